/* rtl/acrf_pkg.sv */
package acrf_pkg;

  // ==========================================================
  // Register map of the configuration bank
  // ==========================================================
  localparam int REG_COUNT = 8;
  localparam int REG_W = 8;
  // Offsets of the eight registers on the write and read port
  localparam logic [7:0] OFS_PWR_DRIVE = 8'h01;
  localparam logic [7:0] OFS_B_HF = 8'h02;
  localparam logic [7:0] OFS_A_HF = 8'h03;
  localparam logic [7:0] OFS_A_PED = 8'h04;
  localparam logic [7:0] OFS_B_PED = 8'h05;
  localparam logic [7:0] OFS_LOOP = 8'h06;
  localparam logic [7:0] OFS_B_SLOW = 8'h07;
  localparam logic [7:0] OFS_SLOW_MASTER = 8'h08;
  // Register indices inside the bank
  localparam int IDX_PWR_DRIVE = 0;
  localparam int IDX_B_HF = 1;
  localparam int IDX_A_HF = 2;
  localparam int IDX_A_PED = 3;
  localparam int IDX_B_PED = 4;
  localparam int IDX_LOOP = 5;
  localparam int IDX_B_SLOW = 6;
  localparam int IDX_SLOW_MASTER = 7;
  localparam logic [7:0] REG_OFS [REG_COUNT] = '{OFS_PWR_DRIVE, OFS_B_HF, OFS_A_HF, OFS_A_PED,
                                                 OFS_B_PED, OFS_LOOP, OFS_B_SLOW, OFS_SLOW_MASTER};
  // Bits that hold state; reserved bits store nothing and read zero
  localparam logic [7:0] REG_MASK [REG_COUNT] = '{8'he4, 8'h01, 8'h01, 8'hfc,
                                                  8'hfc, 8'hbc, 8'h01, 8'h10};
  // Every field comes out of reset at zero
  localparam logic [7:0] REG_RESET = 8'h00;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int BIT_STANDBY = 7;
  localparam int BIT_CLK_DRIVE = 6;
  localparam int BIT_DATA_DRIVE = 5;
  localparam int BIT_POWER_DOWN = 2;
  localparam int BIT_HF = 0;
  localparam int PED_MSB = 7;
  localparam int PED_LSB = 2;
  localparam int PED_W = 6;
  localparam int BIT_HOLD = 7;
  localparam int TC_MSB = 5;
  localparam int TC_LSB = 2;
  localparam int TC_W = 4;
  localparam int BIT_SLOW = 0;
  localparam int BIT_SLOW_MASTER = 4;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_PERIOD_NS = 100;
  localparam int WAKE_TIME_US = 100;
  // Least wake time, rounded up to whole clocks
  localparam int WAKE_CYCLES = (WAKE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W = $clog2(WAKE_CYCLES + 1);

  // ==========================================================
  // Types
  // ==========================================================
  // One register write from the serial configuration front end
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } acrf_wr_t;

  // Controls handed to the analog side
  typedef struct packed {
    logic clk_drive_double;
    logic data_drive_double;
    logic standby_both_channels;
    logic chan_a_powered;
    logic chan_b_powered;
    logic refs_powered;
    logic out_bufs_powered;
    logic chan_a_high_frequency_select;
    logic chan_b_high_frequency_select;
    logic chan_b_slow_rate_active;
  } acrf_ctl_t;

  // Power sequencer states, one-hot
  typedef enum logic [2:0] {
    PWR_RUN = 3'b001,
    PWR_OFF = 3'b010,
    PWR_WAKE = 3'b100
  } acrf_pwr_t;

endpackage

/* rtl/acrf_cfg_reg.sv */
`timescale 1ns/100ps
// One configuration register; only the bits in MASK hold state
module acrf_cfg_reg #(
  parameter logic [7:0] MASK = 8'hff,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] q
);

  // ==========================================================
  // Storage
  // ==========================================================
  logic [7:0] q_reg; // Stored value
  logic [7:0] q_next; // Value after this edge

  // Next value: reserved positions are dropped
  always_comb begin
    q_next = q_reg;
    if (wr_en) begin
      q_next = wr_data & MASK; // R04
    end
  end

  // Register the value
  always_ff @(posedge clk) begin
    if (rst) begin
      q_reg <= RESET_VAL & MASK; // R16
    end else begin
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

endmodule

/* rtl/acrf_offset_est.sv */
`timescale 1ns/100ps
// Offset estimator for one channel: output settles to midcode plus pedestal
module acrf_offset_est #(
  parameter int SAMPLE_W = 14,
  parameter int FRAC_W = 20,
  parameter int TC_BASE = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic loop_on,
  input wire logic hold,
  input wire logic [acrf_pkg::PED_W-1:0] pedestal,
  input wire logic [acrf_pkg::TC_W-1:0] time_const,
  input wire logic signed [SAMPLE_W-1:0] sample_in,
  output logic signed [SAMPLE_W-1:0] sample_out,
  output logic signed [SAMPLE_W+1:0] estimate
);

  localparam int EW = SAMPLE_W + 2 + FRAC_W;
  localparam logic signed [SAMPLE_W+1:0] MAX_OUT = (SAMPLE_W + 2)'((1 << (SAMPLE_W - 1)) - 1);
  localparam logic signed [SAMPLE_W+1:0] MIN_OUT = -MAX_OUT - (SAMPLE_W + 2)'(1);

  // Shift must leave fraction bits below the largest step
  initial begin
    if (FRAC_W <= (1 << acrf_pkg::TC_W) + TC_BASE || SAMPLE_W < 8 || TC_BASE < 0 || TC_BASE > 16) begin
      $error("acrf_offset_est: FRAC_W, SAMPLE_W or TC_BASE out of range");
    end
  end

  // ==========================================================
  // Estimate and corrected sample
  // ==========================================================
  logic signed [EW-1:0] est_reg; // Offset estimate with fraction
  logic signed [EW-1:0] est_next;
  logic signed [SAMPLE_W-1:0] out_reg; // Corrected sample
  logic signed [SAMPLE_W-1:0] out_next;
  logic signed [SAMPLE_W+1:0] corr; // Sample less estimate
  logic signed [SAMPLE_W+1:0] err; // Distance from the target
  logic signed [EW-1:0] err_ext;
  logic [4:0] shift; // Loop time constant as a power of two

  // Next estimate and output; midcode is zero in two's complement
  always_comb begin
    corr = (SAMPLE_W + 2)'(sample_in) - est_reg[EW-1:FRAC_W];
    err = corr - (SAMPLE_W + 2)'(signed'(pedestal));
    err_ext = {err, {FRAC_W{1'b0}}};
    shift = 5'({1'b0, time_const}) + 5'(TC_BASE); // R10
    est_next = est_reg;
    out_next = sample_in;
    if (!loop_on) begin
      est_next = '0; // R14
    end else begin
      if (!hold) begin
        est_next = est_reg + (err_ext >>> shift); // R09
      end
      // Saturate the corrected sample
      if (corr > MAX_OUT) begin
        out_next = MAX_OUT[SAMPLE_W-1:0];
      end else if (corr < MIN_OUT) begin
        out_next = MIN_OUT[SAMPLE_W-1:0];
      end else begin
        out_next = corr[SAMPLE_W-1:0]; // R07
      end
    end
  end

  // Register estimate and output
  always_ff @(posedge clk) begin
    if (rst) begin
      est_reg <= '0;
      out_reg <= '0;
    end else begin
      est_reg <= est_next;
      out_reg <= out_next;
    end
  end

  assign sample_out = out_reg;
  assign estimate = est_reg[EW-1:FRAC_W];

endmodule

/* rtl/acrf_config_bank.sv */
`timescale 1ns/100ps
// Overview of operation
// (R01) Clock drive bit selects double output-clock strength
// (R02) Data drive bit selects double data-buffer strength
// (R03) Power-down stops channels, references, buffers; slow wake
// (R04) Host writes zero into reserved bit positions
// (R05) Channel B high-frequency bit selects its mode
// (R06) Channel A high-frequency bit selects its mode
// (R07) Channel A converges to midcode plus pedestal
// (R08) Channel B has its own pedestal field
// (R09) Hold bit freezes estimate, last value applied
// (R10) Four-bit field sets loop time constant
// (R11) Channel B slow-rate bit enables low-speed mode
// (R12) Host sets master enable before per-channel bit
// (R13) Master enable off keeps low-speed mode disabled
// (R14) Loop enable turns offset correction on
// (R15) Digital enable gates all digital processing
// (R16) All fields reset to zero
module acrf_config_bank #(
  parameter int SAMPLE_W = 14,
  parameter int FRAC_W = 20,
  parameter int TC_BASE = 1,
  parameter int WAKE_CYCLES = acrf_pkg::WAKE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire acrf_pkg::acrf_wr_t cfg_wr,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic digital_enable,
  input wire logic offset_loop_on,
  input wire logic signed [SAMPLE_W-1:0] chan_a_sample,
  input wire logic signed [SAMPLE_W-1:0] chan_b_sample,
  output logic signed [SAMPLE_W-1:0] chan_a_out,
  output logic signed [SAMPLE_W-1:0] chan_b_out,
  output acrf_pkg::acrf_ctl_t ctl,
  output logic wake_busy
);

  // Wake counter must be able to hold the wake time
  initial begin
    if (WAKE_CYCLES < 1 || WAKE_CYCLES >= (1 << 16)) begin
      $error("acrf_config_bank: WAKE_CYCLES out of range");
    end
  end

  // ==========================================================
  // Register bank
  // ==========================================================
  logic [7:0] regs [acrf_pkg::REG_COUNT]; // Stored register values
  logic [acrf_pkg::REG_COUNT-1:0] reg_hit; // Write decode per register

  // Decode the write address to one register
  always_comb begin
    reg_hit = '0;
    for (int i = 0; i < acrf_pkg::REG_COUNT; i++) begin
      reg_hit[i] = cfg_wr.en && (cfg_wr.addr == acrf_pkg::REG_OFS[i]);
    end
  end

  // One storage register per offset
  for (genvar g = 0; g < acrf_pkg::REG_COUNT; g++) begin : g_reg
    acrf_cfg_reg #(
      .MASK(acrf_pkg::REG_MASK[g]),
      .RESET_VAL(acrf_pkg::REG_RESET)
    ) u_reg (
      .clk(clk),
      .rst(rst),
      .wr_en(reg_hit[g]),
      .wr_data(cfg_wr.data),
      .q(regs[g])
    );
  end

  // ==========================================================
  // Read back
  // ==========================================================
  logic [7:0] rd_reg; // Registered read data
  logic [7:0] rd_next;

  // Select the addressed register; unmapped offsets read zero
  always_comb begin
    rd_next = 8'h00;
    for (int i = 0; i < acrf_pkg::REG_COUNT; i++) begin
      if (rd_addr == acrf_pkg::REG_OFS[i]) begin
        rd_next = regs[i];
      end
    end
  end

  // Register the read data
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_reg <= 8'h00;
    end else begin
      rd_reg <= rd_next;
    end
  end

  assign rd_data = rd_reg;

  // ==========================================================
  // Field extraction
  // ==========================================================
  logic [7:0] pwr_drive; // Power and drive register
  logic [7:0] loop_ctl; // Offset loop register
  logic total_power_down; // Global power down field
  logic offset_estimate_hold; // Estimator freeze field
  logic [acrf_pkg::TC_W-1:0] offset_loop_time_const; // Loop time constant field
  logic [acrf_pkg::PED_W-1:0] chan_a_pedestal; // Channel A pedestal field
  logic [acrf_pkg::PED_W-1:0] chan_b_pedestal; // Channel B pedestal field
  logic slow_master; // Low-speed master enable field

  assign pwr_drive = regs[acrf_pkg::IDX_PWR_DRIVE];
  assign loop_ctl = regs[acrf_pkg::IDX_LOOP];
  assign total_power_down = pwr_drive[acrf_pkg::BIT_POWER_DOWN];
  assign offset_estimate_hold = loop_ctl[acrf_pkg::BIT_HOLD];
  assign offset_loop_time_const = loop_ctl[acrf_pkg::TC_MSB:acrf_pkg::TC_LSB];
  assign chan_a_pedestal = regs[acrf_pkg::IDX_A_PED][acrf_pkg::PED_MSB:acrf_pkg::PED_LSB]; // R07
  assign chan_b_pedestal = regs[acrf_pkg::IDX_B_PED][acrf_pkg::PED_MSB:acrf_pkg::PED_LSB]; // R08
  assign slow_master = regs[acrf_pkg::IDX_SLOW_MASTER][acrf_pkg::BIT_SLOW_MASTER];

  // ==========================================================
  // Power sequencer
  // ==========================================================
  acrf_pkg::acrf_pwr_t pwr_reg; // Present power state
  acrf_pkg::acrf_pwr_t pwr_next;
  logic [15:0] wake_cnt_reg; // Clocks left in the wake phase
  logic [15:0] wake_cnt_next;

  // Power state: off while the bit is set, then a timed wake
  always_comb begin
    pwr_next = pwr_reg;
    wake_cnt_next = wake_cnt_reg;
    case (pwr_reg)
      acrf_pkg::PWR_RUN: begin
        if (total_power_down) begin
          pwr_next = acrf_pkg::PWR_OFF; // R03
        end
      end
      acrf_pkg::PWR_OFF: begin
        if (!total_power_down) begin
          pwr_next = acrf_pkg::PWR_WAKE;
          wake_cnt_next = 16'(WAKE_CYCLES - 1); // R03
        end
      end
      acrf_pkg::PWR_WAKE: begin
        if (total_power_down) begin
          pwr_next = acrf_pkg::PWR_OFF;
        end else if (wake_cnt_reg == 16'h0000) begin
          pwr_next = acrf_pkg::PWR_RUN;
        end else begin
          wake_cnt_next = wake_cnt_reg - 16'h0001;
        end
      end
      default: begin
        pwr_next = acrf_pkg::PWR_RUN;
      end
    endcase
  end

  // Register the power state
  always_ff @(posedge clk) begin
    if (rst) begin
      pwr_reg <= acrf_pkg::PWR_RUN; // R16
      wake_cnt_reg <= 16'h0000;
    end else begin
      pwr_reg <= pwr_next;
      wake_cnt_reg <= wake_cnt_next;
    end
  end

  // ==========================================================
  // Analog controls
  // ==========================================================
  acrf_pkg::acrf_ctl_t ctl_reg; // Registered controls
  acrf_pkg::acrf_ctl_t ctl_next;
  logic powered; // Converters, references and buffers on

  // Build the control word from the fields
  always_comb begin
    powered = (pwr_reg == acrf_pkg::PWR_RUN) && !total_power_down;
    ctl_next = '0;
    ctl_next.clk_drive_double = pwr_drive[acrf_pkg::BIT_CLK_DRIVE]; // R01
    ctl_next.data_drive_double = pwr_drive[acrf_pkg::BIT_DATA_DRIVE]; // R02
    ctl_next.standby_both_channels = pwr_drive[acrf_pkg::BIT_STANDBY];
    ctl_next.chan_a_powered = powered; // R03
    ctl_next.chan_b_powered = powered; // R03
    ctl_next.refs_powered = powered; // R03
    ctl_next.out_bufs_powered = powered; // R03
    ctl_next.chan_b_high_frequency_select = regs[acrf_pkg::IDX_B_HF][acrf_pkg::BIT_HF]; // R05
    ctl_next.chan_a_high_frequency_select = regs[acrf_pkg::IDX_A_HF][acrf_pkg::BIT_HF]; // R06
    // Master enable gates the per-channel bit
    ctl_next.chan_b_slow_rate_active = slow_master && regs[acrf_pkg::IDX_B_SLOW][acrf_pkg::BIT_SLOW]; // R11 R13
  end

  // Register the controls
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_reg <= '0; // R16
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  assign ctl = ctl_reg;
  assign wake_busy = (pwr_reg != acrf_pkg::PWR_RUN);

  // ==========================================================
  // Offset correction loops
  // ==========================================================
  logic loop_run; // Loop enabled and digital path enabled

  // Correction runs only with both enables set and power on
  assign loop_run = offset_loop_on && digital_enable && !wake_busy; // R14 R15

  // Channel A estimator
  acrf_offset_est #(
    .SAMPLE_W(SAMPLE_W),
    .FRAC_W(FRAC_W),
    .TC_BASE(TC_BASE)
  ) u_est_a (
    .clk(clk),
    .rst(rst),
    .loop_on(loop_run),
    .hold(offset_estimate_hold),
    .pedestal(chan_a_pedestal),
    .time_const(offset_loop_time_const),
    .sample_in(chan_a_sample),
    .sample_out(chan_a_out),
    .estimate()
  );

  // Channel B estimator with its own pedestal
  acrf_offset_est #(
    .SAMPLE_W(SAMPLE_W),
    .FRAC_W(FRAC_W),
    .TC_BASE(TC_BASE)
  ) u_est_b (
    .clk(clk),
    .rst(rst),
    .loop_on(loop_run),
    .hold(offset_estimate_hold),
    .pedestal(chan_b_pedestal),
    .time_const(offset_loop_time_const),
    .sample_in(chan_b_sample),
    .sample_out(chan_b_out),
    .estimate()
  );

endmodule

/* verification/acrf_config_bank_assertions.sv */
`timescale 1ns/100ps
// ==========================================================
// Port checker for the configuration bank
// ==========================================================
module acrf_config_bank_assertions #(
  parameter int SAMPLE_W = 14,
  parameter int WAKE_CYCLES = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire acrf_pkg::acrf_wr_t cfg_wr,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic digital_enable,
  input wire logic offset_loop_on,
  input wire logic signed [SAMPLE_W-1:0] chan_a_sample,
  input wire logic signed [SAMPLE_W-1:0] chan_b_sample,
  input wire logic signed [SAMPLE_W-1:0] chan_a_out,
  input wire logic signed [SAMPLE_W-1:0] chan_b_out,
  input wire acrf_pkg::acrf_ctl_t ctl,
  input wire logic wake_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] busy_cnt_reg; // Cycles spent away from run
  logic [15:0] busy_cnt_next;
  // Count consecutive busy cycles
  always_comb begin
    busy_cnt_next = wake_busy ? busy_cnt_reg + 16'h0001 : 16'h0000;
    if (rst) begin
      busy_cnt_next = 16'h0000;
    end
  end
  // Register the count
  always_ff @(posedge clk) begin
    busy_cnt_reg <= busy_cnt_next;
  end
  // A single write to one offset, not repeated next cycle
  sequence s_wr_once(logic [7:0] a);
    (cfg_wr.en && cfg_wr.addr == a) ##1 !(cfg_wr.en && cfg_wr.addr == a);
  endsequence
  sequence s_wr_bit(logic [7:0] a, int b, logic v);
    (cfg_wr.en && cfg_wr.addr == a && cfg_wr.data[b] == v) ##1 !(cfg_wr.en && cfg_wr.addr == a);
  endsequence
  a_clk_drive_map: assert property (s_wr_once(acrf_pkg::OFS_PWR_DRIVE) |=>
    ctl.clk_drive_double == $past(cfg_wr.data[6], 2)) else $error("clock drive not following");
  a_data_drive_map: assert property (s_wr_once(acrf_pkg::OFS_PWR_DRIVE) |=>
    ctl.data_drive_double == $past(cfg_wr.data[5], 2)) else $error("data drive not following");
  a_power_down_all: assert property (s_wr_bit(acrf_pkg::OFS_PWR_DRIVE, 2, 1'b1) |=>
    !(ctl.chan_a_powered | ctl.chan_b_powered | ctl.refs_powered | ctl.out_bufs_powered) && wake_busy)
    else $error("power down incomplete");
  a_wake_min_time: assert property ($fell(wake_busy) |-> busy_cnt_reg >= WAKE_CYCLES)
    else $error("wake time too short");
  a_hf_chan_b: assert property (s_wr_once(acrf_pkg::OFS_B_HF) |=>
    ctl.chan_b_high_frequency_select == $past(cfg_wr.data[0], 2)) else $error("chan b hf wrong");
  a_hf_chan_a: assert property (s_wr_once(acrf_pkg::OFS_A_HF) |=>
    ctl.chan_a_high_frequency_select == $past(cfg_wr.data[0], 2)) else $error("chan a hf wrong");
  a_slow_master_off: assert property (s_wr_bit(acrf_pkg::OFS_SLOW_MASTER, 4, 1'b0) |=>
    !ctl.chan_b_slow_rate_active) else $error("slow rate active without master");
  a_loop_off_pass: assert property ((!digital_enable || !offset_loop_on) |=>
    chan_a_out == $past(chan_a_sample) && chan_b_out == $past(chan_b_sample))
    else $error("output not plain delay with loop off");
  a_unmapped_zero: assert property (!($past(rd_addr) inside {[8'h01:8'h08]}) |-> rd_data == 8'h00)
    else $error("unmapped read not zero");
endmodule

/* verification/acrf_host_model.sv */
`timescale 1ns/100ps
// ==========================================================
// Host side of the configuration write port
// ==========================================================
module acrf_host_model (
  input wire logic clk,
  output acrf_pkg::acrf_wr_t cfg_wr
);
  // Idle port at time zero
  initial begin
    cfg_wr = '0;
  end
  // One write after gap + 1 idle cycles; reserved positions are sent as zero
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data, input int gap);
    logic [7:0] keep;
    keep = 8'hff;
    for (int i = 0; i < acrf_pkg::REG_COUNT; i++) begin
      if (acrf_pkg::REG_OFS[i] == addr) begin
        keep = acrf_pkg::REG_MASK[i];
      end
    end
    repeat (gap + 1) @(posedge clk);
    #1;
    cfg_wr = '{en: 1'b1, addr: addr, data: data & keep};
    @(posedge clk);
    #1;
    // Released fields show the inverse so stale values are never trusted
    cfg_wr = '{en: 1'b0, addr: ~addr, data: ~data};
  endtask
endmodule

/* verification/adc_config_register_fields_tb_top.sv */
`timescale 1ns/100ps
// ==========================================================
// Self-checking bench for the configuration bank
// ==========================================================
module adc_config_register_fields_tb_top;
  localparam int WK = 5; // Short wake time
  logic clk;
  logic rst;
  acrf_pkg::acrf_wr_t cfg_wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic digital_enable;
  logic offset_loop_on;
  logic signed [13:0] sa;
  logic signed [13:0] sb;
  logic signed [13:0] chan_a_out;
  logic signed [13:0] chan_b_out;
  acrf_pkg::acrf_ctl_t ctl;
  logic wake_busy;
  int n_mismatch;
  int cmp_count;
  int seed;
  int cyc;
  int n;
  int base;
  logic [7:0] d;
  logic [2:0] k;
  logic [7:0] t_ofs[5] = '{acrf_pkg::OFS_PWR_DRIVE, acrf_pkg::OFS_PWR_DRIVE, acrf_pkg::OFS_A_HF, acrf_pkg::OFS_B_HF,
    acrf_pkg::OFS_PWR_DRIVE};
  logic [7:0] t_dat[5] = '{8'h40, 8'h20, 8'h01, 8'h01, 8'h80};
  logic [9:0] t_bit[5] = '{10'h200, 10'h100, 10'h004, 10'h002, 10'h080};
  logic [5:0] t_ped[4] = '{6'h1f, 6'h00, 6'h3f, 6'h20};
  acrf_host_model u_host (.clk(clk), .cfg_wr(cfg_wr));
  acrf_config_bank #(.WAKE_CYCLES(WK)) u_dut (.clk(clk), .rst(rst), .cfg_wr(cfg_wr), .rd_addr(rd_addr),
    .rd_data(rd_data), .digital_enable(digital_enable), .offset_loop_on(offset_loop_on), .chan_a_sample(sa),
    .chan_b_sample(sb), .chan_a_out(chan_a_out), .chan_b_out(chan_b_out), .ctl(ctl), .wake_busy(wake_busy));
  // Clock generator, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Expected readback keeps only stored bits
  function automatic logic [7:0] masked(input logic [2:0] i, input logic [7:0] v);
    return v & acrf_pkg::REG_MASK[i];
  endfunction
  function automatic int ped(input logic [5:0] c);
    return int'($signed(c));
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_near(input logic signed [13:0] got, input int tgt, input string what);
    cmp_count++;
    if (((got >= tgt - 1) && (got <= tgt + 1)) !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, tgt);
    end
  endtask
  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    wait_cyc(1);
    rd_addr = a;
    wait_cyc(1);
    chk({8'h00, rd_data}, {8'h00, exp}, "register read");
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_host.write_reg(a, v, 0);
    wait_cyc(2);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      give_verdict();
    end
  end
  // Main sequence
  initial begin
    seed = 15;
    rst = 1'b1;
    rd_addr = 8'h00;
    digital_enable = 1'b0;
    offset_loop_on = 1'b0;
    sa = 14'sh0000;
    sb = 14'sh0000;
    wait_cyc(3);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) rd(acrf_pkg::REG_OFS[i], acrf_pkg::REG_RESET);
    chk({6'h00, ctl}, 16'h0078, "ctl after reset");
    $display("test reset done");
    repeat (24) begin
      k = 3'($random(seed));
      d = 8'($random(seed));
      u_host.write_reg(acrf_pkg::REG_OFS[k], d, int'(k[1:0]));
      rd(acrf_pkg::REG_OFS[k], masked(k, d));
    end
    rd(8'h00, 8'h00);
    rd(8'h09, 8'h00);
    for (int i = 0; i < 8; i++) wr(acrf_pkg::REG_OFS[i], 8'h00);
    n = 0;
    while (wake_busy !== 1'b0 && n < 100) begin
      wait_cyc(1);
      n++;
    end
    $display("test readback done");
    for (int i = 0; i < 5; i++) begin
      wr(t_ofs[i], t_dat[i]);
      chk({6'h00, ctl}, {6'h00, 10'h078 | t_bit[i]}, "field set");
      wr(t_ofs[i], 8'h00);
      chk({6'h00, ctl}, 16'h0078, "field clear");
    end
    $display("test fields done");
    wr(acrf_pkg::OFS_PWR_DRIVE, 8'h04);
    chk({5'h00, wake_busy, ctl}, 16'h0400, "powered down");
    u_host.write_reg(acrf_pkg::OFS_PWR_DRIVE, 8'h00, 2);
    n = 0;
    while (wake_busy !== 1'b0 && n < 100) begin
      wait_cyc(1);
      n++;
    end
    chk({15'h0000, n >= WK}, 16'h0001, "wake time");
    wait_cyc(2);
    chk({6'h00, ctl}, 16'h0078, "powered again");
    $display("test power done");
    wr(acrf_pkg::OFS_B_SLOW, 8'h01);
    chk({15'h0000, ctl.chan_b_slow_rate_active}, 16'h0000, "slow without master");
    wr(acrf_pkg::OFS_SLOW_MASTER, 8'h10);
    chk({15'h0000, ctl.chan_b_slow_rate_active}, 16'h0001, "slow with master");
    wr(acrf_pkg::OFS_SLOW_MASTER, 8'h00);
    chk({15'h0000, ctl.chan_b_slow_rate_active}, 16'h0000, "master cleared");
    $display("test slow rate done");
    base = 100 + ($random(seed) & 127);
    sa = 14'(base);
    sb = 14'(base);
    wr(acrf_pkg::OFS_B_PED, 8'hf8);
    wr(acrf_pkg::OFS_LOOP, 8'h3c);
    digital_enable = 1'b1;
    offset_loop_on = 1'b1;
    wait_cyc(20);
    chk_near(chan_a_out, base, "slow loop");
    wr(acrf_pkg::OFS_LOOP, 8'h00);
    foreach (t_ped[i]) begin
      wr(acrf_pkg::OFS_A_PED, {t_ped[i], 2'b00});
      wait_cyc(60);
      chk_near(chan_a_out, ped(t_ped[i]), "pedestal a");
      chk_near(chan_b_out, -2, "pedestal b");
    end
    wr(acrf_pkg::OFS_LOOP, 8'h80);
    sa = 14'(base + 40);
    wait_cyc(10);
    chk_near(chan_a_out, 8, "frozen estimate");
    wr(acrf_pkg::OFS_LOOP, 8'h00);
    wait_cyc(60);
    chk_near(chan_a_out, -32, "unfrozen");
    digital_enable = 1'b0;
    wait_cyc(2);
    chk(16'(chan_a_out), 16'(sa), "digital off");
    digital_enable = 1'b1;
    offset_loop_on = 1'b0;
    wait_cyc(2);
    chk(16'(chan_b_out), 16'(sb), "loop off");
    $display("test offset loop done");
    // Second reset with non-zero fields stored must clear them all
    rst = 1'b1;
    wait_cyc(3);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) rd(acrf_pkg::REG_OFS[i], acrf_pkg::REG_RESET);
    chk({6'h00, ctl}, 16'h0078, "ctl after second reset");
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule
bind acrf_config_bank acrf_config_bank_assertions #(.SAMPLE_W(SAMPLE_W), .WAKE_CYCLES(WAKE_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .cfg_wr(cfg_wr), .rd_addr(rd_addr), .rd_data(rd_data), .digital_enable(digital_enable),
  .offset_loop_on(offset_loop_on), .chan_a_sample(chan_a_sample), .chan_b_sample(chan_b_sample),
  .chan_a_out(chan_a_out), .chan_b_out(chan_b_out), .ctl(ctl), .wake_busy(wake_busy));
